// file: dv/async_backplane_bus_interface_tb_top.sv
// Self-checking bench: processor end and module end on one backplane.
`timescale 1ns/100ps
`include "bus_consts.svh"
module async_backplane_bus_interface_tb_top;
    import bus_pkg::*;
    logic clk_sys_i = 0, srst_i = 1, cmd_valid_i = 0, cmd_byte_i = 0, b, h;
    logic rsp_ready_i = 1, int_enable_i = 0, irq_req_i = 0, dma_valid_i = 0;
    logic cmd_ready_o, rsp_valid_o, rsp_vector_o, dma_active_o;
    logic irq_pend_o, dma_ready_o, dma_done_o, act = 0;
    logic [1:0] i;
    logic [15:0] cmd_addr_i = 0, cmd_wdata_i = 0, dma_addr_i = 0;
    logic [15:0] dma_data_i = 0, rsp_data_o, reg0_o, d, mem[4];
    logic [16:0] exp_q[$];
    cycle_type cmd_type_i = word_read_cycle, t;
    int errors = 0, tests_run = 0, cyc = 0, seed = 17696;

    backplane_if bus_if ();
    bus_cpu_end u_bus_cpu_end (.clk_sys_i, .srst_i, .bus(bus_if),
        .cmd_valid_i, .cmd_ready_o, .cmd_type_i, .cmd_addr_i, .cmd_wdata_i,
        .cmd_byte_i, .int_enable_i, .rsp_valid_o, .rsp_ready_i,
        .rsp_data_o, .rsp_vector_o, .dma_active_o);
    bus_module_end u_bus_module_end (.clk_sys_i, .srst_i, .bus(bus_if),
        .irq_req_i, .irq_pend_o, .dma_valid_i, .dma_ready_o, .dma_addr_i,
        .dma_data_i, .dma_done_o, .reg0_o);
    bus_link_assertions u_bus_link_assertions (.clk_sys_i, .srst_i,
        .da_n(bus_if.da_n), .cpu_da_oe(bus_if.cpu_da_oe),
        .mod_da_oe(bus_if.mod_da_oe), .tc_n(bus_if.tc_n), .id_n(bus_if.id_n));

    always #2.5 clk_sys_i = ~clk_sys_i;
    // Random stalls keep the reply buffer filling and draining.
    always @(posedge clk_sys_i) #1 rsp_ready_i = 1'($random(seed));
    always @(posedge clk_sys_i) begin
        if (++cyc == 20000) begin
            errors++;
            test_done;
        end
        if (dma_active_o === 1'b1) act = 1;
        if (rsp_valid_o === 1'b1 && rsp_ready_i === 1'b1)
            chk({rsp_vector_o, rsp_data_o}, exp_q.pop_front());
    end

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [15:0] a);
        @(posedge clk_sys_i) #1;
        cmd_type_i = t;
        cmd_addr_i = a;
        cmd_wdata_i = d;
        cmd_byte_i = b;
        cmd_valid_i = 1;
        while (cmd_ready_o !== 1'b1) @(posedge clk_sys_i) #1;
        @(posedge clk_sys_i) #1 cmd_valid_i = 0;
    endtask
    task automatic rd_all;
        for (int k = 0; k < 4; k++) begin
            t = word_read_cycle;
            b = 0;
            exp_q.push_back({1'b0, mem[k]});
            cmd({13'h1FE0, k[1:0], 1'b0});
        end
        while (exp_q.size() != 0) @(posedge clk_sys_i);
    endtask
    task automatic test_done;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_sys_i);
        #1 srst_i = 0;
        repeat (2) @(posedge clk_sys_i);
        for (int k = 0; k < 32; k++) begin
            t = cycle_type'(3 - k[1:0]);
            i = k[3:2];
            d = 16'($random(seed));
            b = t == read_modify_write_byte ||
                t == write_word_or_byte_cycle && d[0] && k[4];
            h = b & d[1];
            if (b) d[15:8] = d[7:0];
            if (t != write_word_or_byte_cycle) exp_q.push_back({1'b0, mem[i]});
            cmd({13'h1FE0, i, h});
            if (!b && t != word_read_cycle) mem[i] = d;
            else if (h) mem[i][15:8] = d[15:8];
            else if (b) mem[i][7:0] = d[7:0];
        end
        rd_all;
        chk({1'b0, reg0_o}, {1'b0, mem[0]});
        $display("cycle types done");
        exp_q.push_back({1'b1, `MOD_VECTOR});
        @(posedge clk_sys_i) #1 irq_req_i = 1;
        @(posedge clk_sys_i) #1 irq_req_i = 0;
        repeat (40) @(posedge clk_sys_i);
        chk({16'h0, irq_pend_o}, 17'h1);
        #1 int_enable_i = 1;
        while (exp_q.size() != 0) @(posedge clk_sys_i);
        #1 int_enable_i = 0;
        repeat (20) @(posedge clk_sys_i);
        chk({16'h0, irq_pend_o}, 17'h0);
        chk({16'h0, act}, 17'h0);
        $display("interrupt done");
        d = 16'($random(seed));
        @(posedge clk_sys_i) #1;
        dma_addr_i = 16'hFF01;
        dma_data_i = d;
        dma_valid_i = 1;
        while (dma_ready_o !== 1'b1) @(posedge clk_sys_i) #1;
        @(posedge clk_sys_i) #1 dma_valid_i = 0;
        @(posedge clk_sys_i iff dma_done_o === 1'b1);
        mem[0] = d;
        chk({1'b0, reg0_o}, {1'b0, d});
        chk({16'h0, act}, 17'h1);
        rd_all;
        $display("dma done");
        test_done;
    end
endmodule

// file: dv/bus_link_assertions.sv
// Wire-level checks on the backplane between the two ends.
`timescale 1ns/100ps
`include "bus_consts.svh"
module bus_link_assertions (
    input wire logic        clk_sys_i,
    input wire logic        srst_i,
    input wire logic [15:0] da_n,
    input wire logic [15:0] cpu_da_oe,
    input wire logic [15:0] mod_da_oe,
    input wire logic [5:0]  tc_n,
    input wire logic [9:0]  id_n
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    chk_one_driver: assert property (
        !(|cpu_da_oe && |mod_da_oe)) else $error("two data drivers");
    chk_dout_sync: assert property (
        !tc_n[2] |-> !tc_n[0]) else $error("dout without sync");
    chk_rply_strobe: assert property (
        $fell(tc_n[3]) |-> !(&tc_n[2:1])) else $error("stray reply");
    chk_strobe_held: assert property (
        $rose(tc_n[1]) || $rose(tc_n[2]) |-> !$past(tc_n[3]))
        else $error("strobe dropped early");
    chk_dmg_dmr: assert property (
        $fell(id_n[4]) |-> !id_n[3]) else $error("grant unasked");
    chk_dmg_drop: assert property (
        $fell(id_n[6]) |-> ##[1:8] id_n[4]) else $error("grant held");
    chk_iak_irq: assert property (
        $fell(id_n[1]) |-> !id_n[0]) else $error("ack unasked");
    chk_vector_out: assert property (
        !tc_n[3] && !$past(tc_n[3]) && !id_n[1] |-> da_n == ~`MOD_VECTOR)
        else $error("bad vector");
endmodule

// file: hdl/backplane_if.sv
// Open-collector backplane: each party pulls lines low, the wire resolves.
`timescale 1ns/100ps
`include "bus_consts.svh"
interface backplane_if;
    logic [`DA_W-1:0] cpu_da_o, cpu_da_oe, mod_da_o, mod_da_oe, da_n;
    logic [`AP_W-1:0] cpu_ap_o, cpu_ap_oe, mod_ap_o, mod_ap_oe, ap_n;
    logic [`XA_W-1:0] cpu_xa_o, cpu_xa_oe, mod_xa_o, mod_xa_oe, xa_n;
    logic [`TC_W-1:0] cpu_tc_o, cpu_tc_oe, mod_tc_o, mod_tc_oe, tc_n;
    logic [`SC_W-1:0] cpu_sc_o, cpu_sc_oe, mod_sc_o, mod_sc_oe, sc_n;
    logic [`ID_W-1:0] cpu_id_o, cpu_id_oe, mod_id_o, mod_id_oe, id_n;

    // A line reads low whenever any enabled driver holds it low.
    assign da_n = ~((cpu_da_oe & ~cpu_da_o) | (mod_da_oe & ~mod_da_o));
    assign ap_n = ~((cpu_ap_oe & ~cpu_ap_o) | (mod_ap_oe & ~mod_ap_o));
    assign xa_n = ~((cpu_xa_oe & ~cpu_xa_o) | (mod_xa_oe & ~mod_xa_o));
    assign tc_n = ~((cpu_tc_oe & ~cpu_tc_o) | (mod_tc_oe & ~mod_tc_o));
    assign sc_n = ~((cpu_sc_oe & ~cpu_sc_o) | (mod_sc_oe & ~mod_sc_o));
    assign id_n = ~((cpu_id_oe & ~cpu_id_o) | (mod_id_oe & ~mod_id_o));

    modport cpu_mp (
        output cpu_da_o, cpu_da_oe, cpu_ap_o, cpu_ap_oe, cpu_xa_o,
        output cpu_xa_oe, cpu_tc_o, cpu_tc_oe, cpu_sc_o, cpu_sc_oe,
        output cpu_id_o, cpu_id_oe,
        input  da_n, ap_n, xa_n, tc_n, sc_n, id_n
    );
    modport mod_mp (
        output mod_da_o, mod_da_oe, mod_ap_o, mod_ap_oe, mod_xa_o,
        output mod_xa_oe, mod_tc_o, mod_tc_oe, mod_sc_o, mod_sc_oe,
        output mod_id_o, mod_id_oe,
        input  da_n, ap_n, xa_n, tc_n, sc_n, id_n
    );
endinterface

// file: hdl/bus_consts.svh
// Named constants shared by both ends of the backplane link.
`ifndef BUS_CONSTS_SVH
`define BUS_CONSTS_SVH
`define DA_W      16
`define AP_W      2
`define XA_W      4
`define TC_W      6
`define SC_W      6
`define ID_W      10
`define TC_SYNC   0
`define TC_DIN    1
`define TC_DOUT   2
`define TC_RPLY   3
`define TC_WTBT   4
`define TC_BS7    5
`define ID_IRQ    0
`define ID_IAKI   1
`define ID_IAKO   2
`define ID_DMR    3
`define ID_DMGI   4
`define ID_DMGO   5
`define ID_SACK   6
`define IO_MSB    15
`define IO_LSB    13
`define IO_PAGE   3'h7
`define MOD_BASE  16'hFF00
`define MOD_IDX_MSB 2
`define MOD_IDX_LSB 1
`define MOD_REGS  4
`define MOD_VECTOR 16'h0040
`endif

// file: hdl/bus_cpu_end.sv
// Processor end: bus master, arbiter and interrupt acknowledge.
// Notes on behaviour
// - Lines active low, open collector, pulled low.
// - No shared clock; every step is handshaked.
// - Data lines change direction per transfer.
// - Provide all six bus signal groups.
// - One master; single slave; memory only slave. Here the only slave is the module end's register set.
// - Processor arbitrates and hands over mastership.
// - Two daisy grants; nearest module wins.
// - Pass grant only when not requesting.
// - Granted interrupter supplies vector; no polling.
// - DMA goes to memory, processor registers untouched. Here the DMA write lands in the module end's own registers.
// - Four cycle types: read, two RMW, write.
// - Even word addresses; low byte even.
// - Top 8 KB decoded as device registers.
`timescale 1ns/100ps
`include "bus_consts.svh"
module bus_cpu_end (
    input  wire logic               clk_sys_i,
    input  wire logic               srst_i,
    backplane_if.cpu_mp             bus,
    input  wire logic               cmd_valid_i,
    output logic                    cmd_ready_o,
    input  wire bus_pkg::cycle_type cmd_type_i,
    input  wire logic [`DA_W-1:0]   cmd_addr_i,
    input  wire logic [`DA_W-1:0]   cmd_wdata_i,
    input  wire logic               cmd_byte_i,
    input  wire logic               int_enable_i,
    output logic                    rsp_valid_o,
    input  wire logic               rsp_ready_i,
    output logic [`DA_W-1:0]        rsp_data_o,
    output logic                    rsp_vector_o,
    output logic                    dma_active_o
);
    import bus_pkg::*;
    localparam int SW = `DA_W + `TC_W + `ID_W;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    // Every bus line read here is foreign to this clock, so da_n, tc_n and id_n pass two stages.
    logic [SW-1:0] s1_r, s2_r;
    always_ff @(posedge clk_sys_i) begin
        s1_r <= srst_i ? {SW{1'b1}} : {bus.da_n, bus.tc_n, bus.id_n};
        s2_r <= srst_i ? {SW{1'b1}} : s1_r;
    end
    wire [`DA_W-1:0] in_da = ~s2_r[SW-1 -: `DA_W];
    wire [`TC_W-1:0] in_tc = ~s2_r[`TC_W+`ID_W-1 -: `TC_W];
    wire [`ID_W-1:0] in_id = ~s2_r[`ID_W-1:0];
    wire             rply  = in_tc[`TC_RPLY];

    // ------------------------------------------------------------
    // Master sequencer
    // ------------------------------------------------------------
    cpu_state_type    st_r, st_nxt;
    cycle_type        cyc_r;
    logic [`DA_W-1:0] wdata_r, da_r, da_nxt, push_data;
    logic             byte_r, da_en_r, da_en_nxt, rdy_r, dma_act_r;
    logic [`TC_W-1:0] tc_r, tc_nxt;
    logic             grant_r, grant_nxt, iak_r, iak_nxt;
    logic             take, push, push_vec;
    logic [`DA_W-1:0] out_d_r, hold_d_r;
    logic             out_v_r, hold_v_r, out_vec_r, hold_vec_r;

    wire is_read  = cyc_r != write_word_or_byte_cycle;
    wire is_rmw   = cyc_r == read_modify_write_word ||
                    cyc_r == read_modify_write_byte;
    wire wr_byte  = cyc_r == read_modify_write_byte ||
                    (cyc_r == write_word_or_byte_cycle && byte_r);
    wire cmd_io   = cmd_addr_i[`IO_MSB:`IO_LSB] == `IO_PAGE;
    // Room is checked before a cycle starts, so a reply never waits.
    wire room     = !hold_v_r;

    always_comb begin
        st_nxt = st_r;
        da_nxt = da_r;
        da_en_nxt = da_en_r;
        tc_nxt = tc_r;
        grant_nxt = grant_r;
        iak_nxt = iak_r;
        take = 1'b0;
        push = 1'b0;
        push_vec = 1'b0;
        push_data = in_da;
        case (st_r)
            C_IDLE: begin
                if (cmd_valid_i && rdy_r) begin
                    take = 1'b1;
                    da_nxt = cmd_addr_i;
                    da_en_nxt = 1'b1;
                    tc_nxt[`TC_BS7] = cmd_io;
                    tc_nxt[`TC_WTBT] = cmd_type_i ==
                                       write_word_or_byte_cycle;
                    st_nxt = C_ADDR;
                end else if (in_id[`ID_DMR]) begin
                    grant_nxt = 1'b1;
                    st_nxt = C_GRANT;
                end else if (in_id[`ID_IRQ] && int_enable_i && room) begin
                    tc_nxt[`TC_DIN] = 1'b1;
                    st_nxt = C_IAK;
                end
            end
            C_ADDR: begin
                tc_nxt[`TC_SYNC] = 1'b1;
                st_nxt = C_SYNC;
            end
            C_SYNC: begin
                tc_nxt[`TC_BS7] = 1'b0;
                tc_nxt[`TC_WTBT] = 1'b0;
                if (is_read) begin
                    da_en_nxt = 1'b0;
                    tc_nxt[`TC_DIN] = 1'b1;
                    st_nxt = C_RD;
                end else begin
                    da_nxt = wdata_r;
                    tc_nxt[`TC_WTBT] = wr_byte;
                    st_nxt = C_WSET;
                end
            end
            // Data is taken with the reply, before the slave lets go.
            C_RD: if (rply) begin
                push = 1'b1;
                tc_nxt[`TC_DIN] = 1'b0;
                st_nxt = C_RDEND;
            end
            C_RDEND: if (!rply) begin
                if (is_rmw) begin
                    da_nxt = wdata_r;
                    da_en_nxt = 1'b1;
                    tc_nxt[`TC_WTBT] = wr_byte;
                    st_nxt = C_WSET;
                end else begin
                    st_nxt = C_DONE;
                end
            end
            C_WSET: begin
                tc_nxt[`TC_DOUT] = 1'b1;
                st_nxt = C_WR;
            end
            C_WR: if (rply) begin
                tc_nxt[`TC_DOUT] = 1'b0;
                st_nxt = C_WREND;
            end
            C_WREND: if (!rply) begin
                da_en_nxt = 1'b0;
                tc_nxt[`TC_WTBT] = 1'b0;
                st_nxt = C_DONE;
            end
            C_DONE: begin
                tc_nxt[`TC_SYNC] = 1'b0;
                st_nxt = C_IDLE;
            end
            // Withdraw the grant if the requester gave up before taking it.
            C_GRANT: begin
                if (in_id[`ID_SACK]) begin
                    grant_nxt = 1'b0;
                    st_nxt = C_DMA;
                end else if (!in_id[`ID_DMR]) begin
                    grant_nxt = 1'b0;
                    st_nxt = C_IDLE;
                end
            end
            C_DMA: if (!in_id[`ID_SACK]) begin
                st_nxt = C_IDLE;
            end
            C_IAK: begin
                iak_nxt = 1'b1;
                st_nxt = C_IAKW;
            end
            C_IAKW: begin
                if (rply) begin
                    push = 1'b1;
                    push_vec = 1'b1;
                    iak_nxt = 1'b0;
                    tc_nxt[`TC_DIN] = 1'b0;
                    st_nxt = C_IAKEND;
                end else if (!in_id[`ID_IRQ]) begin
                    iak_nxt = 1'b0;
                    tc_nxt[`TC_DIN] = 1'b0;
                    st_nxt = C_IAKEND;
                end
            end
            C_IAKEND: if (!rply) begin
                st_nxt = C_IDLE;
            end
            default: st_nxt = C_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st_r <= C_IDLE;
            cyc_r <= word_read_cycle;
            wdata_r <= 16'h0000;
            byte_r <= 1'b0;
            da_r <= 16'h0000;
            da_en_r <= 1'b0;
            tc_r <= 6'h00;
            grant_r <= 1'b0;
            iak_r <= 1'b0;
            rdy_r <= 1'b0;
            dma_act_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (take) begin
                cyc_r <= cmd_type_i;
                wdata_r <= cmd_wdata_i;
                byte_r <= cmd_byte_i;
            end
            da_r <= da_nxt;
            da_en_r <= da_en_nxt;
            tc_r <= tc_nxt;
            grant_r <= grant_nxt;
            iak_r <= iak_nxt;
            rdy_r <= st_nxt == C_IDLE && !hold_v_r && !push;
            dma_act_r <= st_nxt == C_DMA;
        end
    end

    // ------------------------------------------------------------
    // Two-entry reply buffer
    // ------------------------------------------------------------
    // The head entry feeds the outputs; the second absorbs one stall.
    wire pop = out_v_r && rsp_ready_i;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            out_v_r <= 1'b0;
            hold_v_r <= 1'b0;
            out_d_r <= 16'h0000;
            hold_d_r <= 16'h0000;
            out_vec_r <= 1'b0;
            hold_vec_r <= 1'b0;
        end else if (pop && hold_v_r) begin
            out_d_r <= hold_d_r;
            out_vec_r <= hold_vec_r;
            hold_v_r <= push;
            hold_d_r <= push_data;
            hold_vec_r <= push_vec;
        end else if (pop || !out_v_r) begin
            out_v_r <= push;
            out_d_r <= push_data;
            out_vec_r <= push_vec;
        end else if (push) begin
            hold_v_r <= 1'b1;
            hold_d_r <= push_data;
            hold_vec_r <= push_vec;
        end
    end

    // Group widths come from the interface: 16, 2, 4, 6, 6 and 10.
    assign bus.cpu_da_o  = ~da_r;
    assign bus.cpu_da_oe = {`DA_W{da_en_r}};
    assign bus.cpu_tc_o  = '0;
    assign bus.cpu_tc_oe = tc_r;
    assign bus.cpu_id_o  = '0;
    assign bus.cpu_id_oe = {5'h00, grant_r, 2'h0, iak_r, 1'b0};
    assign bus.cpu_ap_o  = '0;
    assign bus.cpu_ap_oe = '0;
    assign bus.cpu_xa_o  = '0;
    assign bus.cpu_xa_oe = '0;
    assign bus.cpu_sc_o  = '0;
    assign bus.cpu_sc_oe = '0;
    assign cmd_ready_o  = rdy_r;
    assign rsp_valid_o  = out_v_r;
    assign rsp_data_o   = out_d_r;
    assign rsp_vector_o = out_vec_r;
    assign dma_active_o = dma_act_r;
endmodule

// file: hdl/bus_module_end.sv
// Peripheral end: register slave, vectored interrupt and DMA write master.
`timescale 1ns/100ps
`include "bus_consts.svh"
module bus_module_end (
    input  wire logic               clk_sys_i,
    input  wire logic               srst_i,
    backplane_if.mod_mp             bus,
    input  wire logic               irq_req_i,
    output logic                    irq_pend_o,
    input  wire logic               dma_valid_i,
    output logic                    dma_ready_o,
    input  wire logic [`DA_W-1:0]   dma_addr_i,
    input  wire logic [`DA_W-1:0]   dma_data_i,
    output logic                    dma_done_o,
    output logic [`DA_W-1:0]        reg0_o
);
    import bus_pkg::*;
    localparam int SW = `DA_W + `TC_W + `ID_W;
    localparam logic [`DA_W-1:0] BASE = `MOD_BASE;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [SW-1:0] s1_r, s2_r;
    always_ff @(posedge clk_sys_i) begin
        s1_r <= srst_i ? {SW{1'b1}} : {bus.da_n, bus.tc_n, bus.id_n};
        s2_r <= srst_i ? {SW{1'b1}} : s1_r;
    end
    wire [`DA_W-1:0] in_da  = ~s2_r[SW-1 -: `DA_W];
    wire [`TC_W-1:0] in_tc  = ~s2_r[`TC_W+`ID_W-1 -: `TC_W];
    wire [`ID_W-1:0] in_id  = ~s2_r[`ID_W-1:0];
    wire             hit    = in_tc[`TC_BS7] &&
                              in_da[`DA_W-1:3] == BASE[`DA_W-1:3];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    slv_state_type    s_r, s_nxt;
    dma_state_type    m_r, m_nxt;
    logic [`DA_W-1:0] regs_r [`MOD_REGS];
    logic [1:0]       idx_r;
    logic             lane_r, pend_r, iako_r, dmgo_r, rdy_r, done_r;
    logic [`DA_W-1:0] maddr_r, mdata_r, da_r, da_nxt;
    logic             da_en_r, da_en_nxt, wr_en;
    logic [`TC_W-1:0] tc_r, tc_nxt;
    logic             vec_take, m_take;

    wire m_req  = m_r == M_REQ;
    wire iako_nxt = in_id[`ID_IAKI] && (iako_r || !pend_r);
    wire dmgo_nxt = in_id[`ID_DMGI] && (dmgo_r || !m_req);

    always_comb begin
        s_nxt = s_r;
        m_nxt = m_r;
        da_nxt = da_r;
        da_en_nxt = da_en_r;
        tc_nxt = tc_r;
        wr_en = 1'b0;
        vec_take = 1'b0;
        m_take = 1'b0;
        case (s_r)
            S_IDLE: begin
                if (in_id[`ID_IAKI] && in_tc[`TC_DIN] && pend_r &&
                    !iako_r) begin
                    vec_take = 1'b1;
                    da_nxt = `MOD_VECTOR;
                    da_en_nxt = 1'b1;
                    tc_nxt[`TC_RPLY] = 1'b1;
                    s_nxt = S_VEC;
                end else if (in_tc[`TC_SYNC] && hit) begin
                    s_nxt = S_SEL;
                end
            end
            S_SEL: begin
                if (!in_tc[`TC_SYNC]) begin
                    s_nxt = S_IDLE;
                end else if (in_tc[`TC_DIN]) begin
                    da_nxt = regs_r[idx_r];
                    da_en_nxt = 1'b1;
                    tc_nxt[`TC_RPLY] = 1'b1;
                    s_nxt = S_RD;
                end else if (in_tc[`TC_DOUT]) begin
                    wr_en = 1'b1;
                    tc_nxt[`TC_RPLY] = 1'b1;
                    s_nxt = S_WR;
                end
            end
            S_RD: begin
                if (!in_tc[`TC_DIN]) begin
                    da_en_nxt = 1'b0;
                    tc_nxt[`TC_RPLY] = 1'b0;
                    s_nxt = S_SEL;
                end
            end
            S_WR: begin
                if (!in_tc[`TC_DOUT]) begin
                    tc_nxt[`TC_RPLY] = 1'b0;
                    s_nxt = S_SEL;
                end
            end
            S_VEC: begin
                if (!in_id[`ID_IAKI] || !in_tc[`TC_DIN]) begin
                    da_en_nxt = 1'b0;
                    tc_nxt[`TC_RPLY] = 1'b0;
                    s_nxt = S_IDLE;
                end
            end
            default: s_nxt = S_IDLE;
        endcase
        case (m_r)
            M_IDLE: if (dma_valid_i && rdy_r) begin
                m_take = 1'b1;
                m_nxt = M_REQ;
            end
            // Wait for a grant and a quiet bus before claiming it.
            M_REQ: if (in_id[`ID_DMGI] && !dmgo_r && !in_tc[`TC_SYNC] &&
                       !in_tc[`TC_RPLY]) begin
                m_nxt = M_ADDR;
            end
            M_ADDR: begin
                da_nxt = maddr_r;
                da_en_nxt = 1'b1;
                tc_nxt[`TC_BS7] = maddr_r[`IO_MSB:`IO_LSB] == `IO_PAGE;
                tc_nxt[`TC_WTBT] = 1'b1;
                m_nxt = M_SYNC;
            end
            M_SYNC: begin
                tc_nxt[`TC_SYNC] = 1'b1;
                m_nxt = M_DSET;
            end
            M_DSET: begin
                da_nxt = mdata_r;
                tc_nxt[`TC_BS7] = 1'b0;
                tc_nxt[`TC_WTBT] = 1'b0;
                m_nxt = M_DOUT;
            end
            M_DOUT: begin
                tc_nxt[`TC_DOUT] = 1'b1;
                m_nxt = M_WAIT;
            end
            M_WAIT: if (in_tc[`TC_RPLY]) begin
                tc_nxt[`TC_DOUT] = 1'b0;
                m_nxt = M_END;
            end
            M_END: begin
                if (!in_tc[`TC_RPLY] && !in_tc[`TC_DOUT]) begin
                    // Only our own slave can be addressed here, and a write
                    // leaves it nothing to drive, so the lines go free.
                    da_en_nxt = 1'b0;
                    tc_nxt[`TC_SYNC] = 1'b0;
                    m_nxt = M_IDLE;
                end
            end
            default: m_nxt = M_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Byte writes pick the lane from the low address bit.
    genvar g;
    generate
        for (g = 0; g < `MOD_REGS; g++) begin : g_reg
            wire sel = wr_en && idx_r == 2'(g);
            wire byt = in_tc[`TC_WTBT];
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    regs_r[g] <= 16'h0000;
                end else if (sel) begin
                    if (!byt || !lane_r) begin
                        regs_r[g][7:0] <= in_da[7:0];
                    end
                    if (!byt || lane_r) begin
                        regs_r[g][15:8] <= in_da[15:8];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_r <= S_IDLE;
            m_r <= M_IDLE;
            idx_r <= 2'h0;
            lane_r <= 1'b0;
            pend_r <= 1'b0;
            iako_r <= 1'b0;
            dmgo_r <= 1'b0;
            rdy_r <= 1'b0;
            done_r <= 1'b0;
            maddr_r <= 16'h0000;
            mdata_r <= 16'h0000;
            da_r <= 16'h0000;
            da_en_r <= 1'b0;
            tc_r <= 6'h00;
        end else begin
            s_r <= s_nxt;
            m_r <= m_nxt;
            if (s_r == S_IDLE) begin
                idx_r <= in_da[`MOD_IDX_MSB:`MOD_IDX_LSB];
                lane_r <= in_da[0];
            end
            // A new request in the taking cycle stays pending.
            pend_r <= irq_req_i || (pend_r && !vec_take);
            iako_r <= iako_nxt;
            dmgo_r <= dmgo_nxt;
            rdy_r <= m_nxt == M_IDLE;
            done_r <= m_r == M_END && m_nxt == M_IDLE;
            if (m_take) begin
                maddr_r <= {dma_addr_i[`DA_W-1:1], 1'b0};
                mdata_r <= dma_data_i;
            end
            da_r <= da_nxt;
            da_en_r <= da_en_nxt;
            tc_r <= tc_nxt;
        end
    end

    // Lines are only ever pulled low; the o value is the wire level.
    assign bus.mod_da_o  = ~da_r;
    assign bus.mod_da_oe = {`DA_W{da_en_r}};
    assign bus.mod_tc_o  = '0;
    assign bus.mod_tc_oe = tc_r;
    assign bus.mod_id_o  = '0;
    assign bus.mod_id_oe = {3'h0, (m_r >= M_ADDR), dmgo_r, 1'b0,
                            m_req, iako_r, 1'b0, pend_r};
    assign bus.mod_ap_o  = '0;
    assign bus.mod_ap_oe = '0;
    assign bus.mod_xa_o  = '0;
    assign bus.mod_xa_oe = '0;
    assign bus.mod_sc_o  = '0;
    assign bus.mod_sc_oe = '0;
    assign irq_pend_o  = pend_r;
    assign dma_ready_o = rdy_r;
    assign dma_done_o  = done_r;
    assign reg0_o      = regs_r[0];
endmodule

// file: hdl/bus_pkg.sv
// Types shared by both ends of the backplane link.
package bus_pkg;
    typedef enum logic [1:0] {
        word_read_cycle          = 2'h0,
        read_modify_write_word   = 2'h1,
        read_modify_write_byte   = 2'h2,
        write_word_or_byte_cycle = 2'h3
    } cycle_type;

    typedef enum logic [3:0] {
        C_IDLE = 4'h0, C_ADDR = 4'h1, C_SYNC = 4'h2, C_RD = 4'h3,
        C_RDEND = 4'h4, C_WSET = 4'h5, C_WR = 4'h6, C_WREND = 4'h7,
        C_DONE = 4'h8, C_GRANT = 4'h9, C_DMA = 4'hA, C_IAK = 4'hB,
        C_IAKW = 4'hC, C_IAKEND = 4'hD
    } cpu_state_type;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_SEL = 3'h1, S_RD = 3'h2, S_WR = 3'h3,
        S_VEC = 3'h4
    } slv_state_type;

    typedef enum logic [2:0] {
        M_IDLE = 3'h0, M_REQ = 3'h1, M_ADDR = 3'h2, M_SYNC = 3'h3,
        M_DSET = 3'h4, M_DOUT = 3'h5, M_WAIT = 3'h6, M_END = 3'h7
    } dma_state_type;
endpackage
